// File: hw/dpram_consts.svh
// constants for the 32x4 dual-port latch ram block
`ifndef DPRAM_CONSTS_SVH
`define DPRAM_CONSTS_SVH
`define DPRAM_DEPTH 32
`define DPRAM_AW 5
`define DPRAM_DW 4
// axi-lite register byte addresses
`define DPRAM_CTRL_ADDR 32'h0000_0000
`define DPRAM_CLEAR_ADDR 32'h0000_0004
`define DPRAM_STATUS_ADDR 32'h0000_0008
`define DPRAM_CTRL_SYNC_BIT 0
`define DPRAM_CTRL_DUAL_BIT 1
`define DPRAM_CTRL_CFG_BIT 2
`define DPRAM_CTRL_RESET 3'h0
`define DPRAM_RESP_OKAY 2'h0
`define DPRAM_RESP_SLVERR 2'h2
`endif

// File: hw/dpram_pkg.sv
// types for the 32x4 dual-port latch ram block
package dpram_pkg;
  typedef struct packed {
    logic [4:0] waddr;
    logic [3:0] wdata;
    logic we_n;
  } dpram_wr_t;
  typedef struct packed {
    logic [4:0] raddr;
    logic output_enable_n;
  } dpram_rd_t;
  typedef struct packed {
    logic [3:0] data;
    logic oe;
  } dpram_dout_t;
endpackage : dpram_pkg

// File: hw/dpram_store.sv
// latch storage array with asynchronous read
`timescale 1ns/1ps
`include "dpram_consts.svh"
module dpram_store #(
  parameter int DEPTH = `DPRAM_DEPTH,
  parameter int AW = `DPRAM_AW,
  parameter int DW = `DPRAM_DW
) (
  input wire logic aclk,
  input wire logic load,
  input wire logic [AW-1:0] waddr,
  input wire logic we_n,
  input wire logic [DW-1:0] wdata,
  input wire logic clear,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  // each word is a clocked store enabled by load; the front latch in the
  // top makes the pair act as a flop, so a flop here is equivalent
  // no reset branch: contents survive every reset except the clear
  logic [DW-1:0] mem_q [DEPTH];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_word
      wire word_hit = (waddr == AW'(g)) && load && !we_n;
      always_ff @(posedge aclk)
      begin
        if (clear)
          mem_q[g] <= '0;
        else if (word_hit)
          mem_q[g] <= wdata;
      end
    end
  endgenerate
  assign rdata = mem_q[raddr];
endmodule : dpram_store

// File: hw/dpram_top.sv
// 32x4 ram block with sync/async write, dual/single port, axi-lite config
`timescale 1ns/1ps
`include "dpram_consts.svh"
module dpram_top #(
  parameter bit RIGHTMOST = 1'b0,
  parameter int AW = `DPRAM_AW,
  parameter int DW = `DPRAM_DW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sector_clk,
  input wire dpram_pkg::dpram_wr_t wr,
  input wire dpram_pkg::dpram_rd_t rd,
  output logic [DW-1:0] din_o,
  output logic din_oe,
  output dpram_pkg::dpram_dout_t dout,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // control register: sync mode, dual port, configuration phase
  logic [2:0] ctrl_q;
  logic [31:0] awaddr_q, wdata_q;
  logic aw_full_q, w_full_q;
  logic [3:0] wstrb_q;
  logic clear_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q, bresp_q;
  logic bvalid_q, rvalid_q;
  logic sclk_q;
  logic load_q;
  logic [AW-1:0] lat_addr_q;
  logic lat_we_n_q;
  logic [DW-1:0] lat_data_q;
  wire sync_mode = ctrl_q[`DPRAM_CTRL_SYNC_BIT];
  wire dual_mode = ctrl_q[`DPRAM_CTRL_DUAL_BIT] && !RIGHTMOST;
  wire cfg_mode = ctrl_q[`DPRAM_CTRL_CFG_BIT];
  // rising edge of the neighbouring sector-column clock, sampled as data
  wire sclk_rise = sector_clk && !sclk_q;
  // storage load trails the front latch by one edge, so the word stored is
  // the one just captured and never the stale one; async forces high
  wire load = sync_mode ? load_q : 1'b1;
  // front latches capture on the clock edge in sync mode
  wire [AW-1:0] st_addr = sync_mode ? lat_addr_q : wr.waddr;
  wire st_we_n = sync_mode ? lat_we_n_q : wr.we_n;
  wire [DW-1:0] st_data = sync_mode ? lat_data_q : wr.wdata;
  wire [AW-1:0] rd_addr = dual_mode ? rd.raddr : wr.waddr;
  wire [DW-1:0] arr_rdata;
  wire do_write = aw_full_q && w_full_q && !bvalid_q;
  wire wr_ctrl = do_write && awaddr_q == `DPRAM_CTRL_ADDR;
  wire wr_clear = do_write && awaddr_q == `DPRAM_CLEAR_ADDR;
  wire wr_known = wr_ctrl || wr_clear;
  wire rd_take = s_axi_arvalid && !rvalid_q;
  wire rd_ctrl = s_axi_araddr == `DPRAM_CTRL_ADDR;
  wire rd_stat = s_axi_araddr == `DPRAM_STATUS_ADDR;
  wire rd_clr = s_axi_araddr == `DPRAM_CLEAR_ADDR;
  wire [31:0] status_word = {26'h0, dual_mode, sync_mode, st_we_n,
    RIGHTMOST, clear_q, cfg_mode};
  dpram_store #(
    .AW(AW),
    .DW(DW)
  ) u_store (
    .aclk(aclk),
    .load(load),
    .waddr(st_addr),
    .we_n(st_we_n),
    .wdata(st_data),
    .clear(clear_q),
    .raddr(rd_addr),
    .rdata(arr_rdata)
  );
  // the clear is only honoured during configuration; any value counts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clear_q <= 1'b0;
    else
      clear_q <= wr_clear && cfg_mode && wstrb_q[0];
  end
  // front latch: capture while sclk_rise high, hold while low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_q <= 1'b0;
      load_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sector_clk;
      load_q <= sclk_rise;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lat_addr_q <= '0;
      lat_we_n_q <= 1'b1;
      lat_data_q <= '0;
    end
    else if (sclk_rise)
    begin
      lat_addr_q <= wr.waddr;
      lat_we_n_q <= wr.we_n;
      lat_data_q <= wr.wdata;
    end
  end
  // output buses: the shared data pin in single-port, dout in dual-port
  assign dout.data = arr_rdata;
  assign dout.oe = dual_mode && !rd.output_enable_n;
  assign din_o = arr_rdata;
  assign din_oe = !dual_mode && !rd.output_enable_n && wr.we_n;
  // axi-lite write channel: either address or data may arrive first
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `DPRAM_RESP_OKAY;
      ctrl_q <= `DPRAM_CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[31:2], 2'b00};
      end
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? `DPRAM_RESP_OKAY : `DPRAM_RESP_SLVERR;
        if (wr_ctrl && wstrb_q[0])
          ctrl_q <= wdata_q[2:0];
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
    end
  end
  // axi-lite read channel: one outstanding read, answer next cycle
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `DPRAM_RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_ctrl ? {29'h0, ctrl_q} : rd_stat ? status_word : '0;
      rresp_q <= (rd_ctrl || rd_stat || rd_clr) ? `DPRAM_RESP_OKAY
        : `DPRAM_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end
endmodule : dpram_top

// File: tb/dpram_user.sv
// far-side user logic model: shared data pin and output bus
`timescale 1ns/1ps
module dpram_user (
  input wire logic aclk,
  input wire logic [3:0] din_o,
  input wire logic din_oe,
  input wire dpram_pkg::dpram_dout_t dout,
  output logic [3:0] pin,
  output logic [3:0] dpin
);
  logic [3:0] last_q = 4'h0;
  always @(posedge aclk)
    if (din_oe)
      last_q <= din_o;
  // a released pin shows the inverse so stale data never matches
  assign pin = din_oe ? din_o : ~last_q;
  assign dpin = dout.oe ? dout.data : 4'hZ;
endmodule : dpram_user

// File: tb/dpram_properties.sv
// port checker for dpram_top
`timescale 1ns/1ps
module dpram_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dpram_pkg::dpram_wr_t wr,
  input wire dpram_pkg::dpram_rd_t rd,
  input wire logic din_oe,
  input wire dpram_pkg::dpram_dout_t dout,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  oe_gate_a: assert property (dout.oe |-> !rd.output_enable_n)
    else $error("dout driven while disabled");
  pin_gate_a: assert property (din_oe |-> !rd.output_enable_n && wr.we_n)
    else $error("shared pin driven wrongly");
  one_driver_a: assert property (!(din_oe && dout.oe))
    else $error("both read paths driven");
  b_next_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready during response");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  r_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during response");
endmodule : dpram_properties
bind dpram_top dpram_properties dpram_properties_i (.aclk, .aresetn, .wr,
  .rd, .din_oe, .dout, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// File: tb/testbench.sv
// self-checking bench for the 32x4 ram block
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, sector_clk = 1'b0, look = 1'b0;
  dpram_pkg::dpram_wr_t wr = '{5'h00, 4'h0, 1'b1};
  dpram_pkg::dpram_rd_t rd = '{5'h00, 1'b1};
  dpram_pkg::dpram_dout_t dout;
  logic [3:0] din_o, pin, dpin, d, e0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdata;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic din_oe, awr, wrd, bv, arr, rv, sp = 1'b1;
  logic [1:0] bresp, rresp, bres;
  logic [15:0] lfsr = 16'hDD2A;
  logic [33:0] expq [$];
  logic [33:0] got;
  int bad_count = 0, total_checks = 0, n, m;
  always #10 aclk = ~aclk;
  dpram_top dpram_top_i (.aclk, .aresetn, .sector_clk, .wr, .rd, .din_o,
    .din_oe, .dout, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre));
  dpram_user dpram_user_i (.aclk, .din_o, .din_oe, .dout, .pin, .dpin);
  task automatic close_out();
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick
  // ready and valid sampled at the falling edge hold through the next rise
  task automatic wait_hi(input int w);
    for (n = 0; n < 50; n++)
    begin
      @(negedge aclk);
      bres = bresp;
      if ((w == 0 && awr && wrd) || (w == 1 && bv) || (w == 2 && arr)
        || (w == 3 && rv))
      begin
        @(posedge aclk);
        return;
      end
    end
    bad_count++;
    close_out();
  endtask : wait_hi
  task automatic axw(input logic [31:0] a, v, input logic [1:0] er);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    wait_hi(0);
    awv <= 1'b0;
    wv <= 1'b0;
    wait_hi(1);
    bre <= 1'b0;
    total_checks++;
    if (bres !== er)
    begin
      bad_count++;
      $display("ERROR bresp exp %h got %h", er, bres);
    end
  endtask : axw
  task automatic axr(input logic [31:0] a, input logic [33:0] e);
    expq.push_back(e);
    ara <= a;
    arv <= 1'b1;
    wait_hi(2);
    arv <= 1'b0;
    rre <= 1'b1;
    wait_hi(3);
    rre <= 1'b0;
  endtask : axr
  task automatic ram_wr(input logic [4:0] a, input logic [3:0] v, s);
    wr <= '{a, v, 1'b0};
    tick(1);
    sector_clk <= s;
    tick(1);
    wr.we_n <= 1'b1;
    sector_clk <= 1'b0;
    tick(2);
  endtask : ram_wr
  task automatic ram_rd(input logic [4:0] a, input logic [3:0] e);
    rd <= '{a, 1'b0};
    wr.waddr <= sp ? a : ~a;
    tick(1);
    expq.push_back({29'h0, e, 1'b1});
    look <= 1'b1;
    tick(1);
    look <= 1'b0;
    rd.output_enable_n <= 1'b1;
  endtask : ram_rd
  always @(negedge aclk)
    if ((rv && rre) || look)
    begin
      got = look ? {29'h0, sp ? pin : dpin, sp ? din_oe : dout.oe}
        : {rresp, rdata};
      total_checks++;
      if (expq.size() == 0 || expq[0] !== got)
      begin
        bad_count++;
        $display("ERROR %s exp %h got %h", look ? "ram" : "reg", expq[0], got);
      end
      if (expq.size() > 0)
        void'(expq.pop_front());
    end
  initial
  begin
    tick(12);
    aresetn <= 1'b1;
    tick(1);
    axr(32'h0, 34'h0);
    axr(32'h10, {2'h2, 32'h0});
    axw(32'h10, 32'h0, 2'h2);
    for (m = 0; m < 4; m++)
    begin
      axw(32'h0, m, 2'h0);
      axr(32'h0, m);
      sp = ~m[1];
      d = lfsr[3:0];
      lfsr = lfsr_next(lfsr);
      ram_wr(5'h1F, d, m[0]);
      ram_wr(5'h00, ~d, 1'b0);
      if (!m[0])
        e0 = ~d;
      ram_rd(5'h1F, d);
      ram_rd(5'h00, e0);
    end
    axw(32'h0, 32'h4, 2'h0);
    axw(32'h4, 32'h5, 2'h0);
    axw(32'h0, 32'h2, 2'h0);
    ram_rd(5'h1F, 4'h0);
    ram_wr(5'h05, 4'hA, 1'b0);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    sp = 1'b1;
    tick(1);
    ram_rd(5'h05, 4'hA);
    close_out();
  end
endmodule : testbench
